// ==== rtl/comparator_input_control.sv ====
// Purpose: Digital control around one comparator channel with AXI4-Lite registers
// Assumes: All inputs synchronous to core_clk_i
// Notes: Comparator decision arrives as a level on cmp_raw_i
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "comparator_input_control_regs.svh"
module comparator_input_control
    import comparator_input_control_pkg::*;
#(
    parameter int RESULT_PIN = 0
)
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp_raw_i,
    input wire logic other_result_i,
    input wire logic [7:0] port_pins_i,
    output logic [3:0] pos_route_o,
    output logic [3:0] neg_route_o,
    output logic speed_power_select_o,
    output logic hysteresis_enable_o,
    output logic timer_sync_enable_o,
    output logic comparator_result_o,
    output logic result_pin_oe_o,
    output logic [1:0] pwm_shutdown_src_o,
    output logic [7:0] analog_pin_select_o,
    output logic [7:0] pin_direction_o,
    output logic irq_o
);

    ctrl_state_type r;
    ctrl_state_type r_nxt;
    logic edge_event;
    logic wr_fire;
    logic rd_fire;
    logic rd_status;
    logic [7:0] rd_byte;
    logic rd_ok;

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    edge_irq_detect edge_irq_detect_inst (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .result_i(r.result),
        .rise_en_i(r.ctrl1[`CTRL1_RISE_BIT]),
        .fall_en_i(r.ctrl1[`CTRL1_FALL_BIT]),
        .event_o(edge_event)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        r_nxt = r;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        rd_status = 1'b0;
        rd_byte = 8'h00;
        rd_ok = 1'b1;

        // Comparator path, latched each cycle
        if (r.ctrl0[`CTRL0_EN_BIT]) begin
            r_nxt.result = cmp_raw_i ^ r.ctrl0[`CTRL0_INVERT_BIT];
        end else begin
            // Disabled output sits low before inversion
            r_nxt.result = r.ctrl0[`CTRL0_INVERT_BIT];
        end
        r_nxt.other = other_result_i;

        // Input switch closures
        r_nxt.pos_route = 4'h0;
        r_nxt.neg_route = 4'h0;
        if (r.ctrl0[`CTRL0_EN_BIT]) begin
            case (pos_src_type'(r.ctrl1[`CTRL1_POS_LSB +: 2]))
                POS_EXT_PIN: r_nxt.pos_route = 4'h1;
                POS_DAC: r_nxt.pos_route = 4'h2;
                POS_FIXED_REF: r_nxt.pos_route = 4'h4;
                POS_GROUND: r_nxt.pos_route = 4'h8;
                default: r_nxt.pos_route = 4'h0;
            endcase
            r_nxt.neg_route = 4'(4'h1 << r.ctrl1[`CTRL1_NEG_LSB +: 2]);
        end
        r_nxt.pin_oe = r.ctrl0[`CTRL0_PIN_EN_BIT] && !r.dir[RESULT_PIN];

        // Write channel capture
        if (s_axi_awvalid && r.awready) begin
            r_nxt.aw_held = 1'b1;
            r_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            r_nxt.w_held = 1'b1;
            r_nxt.w_data = s_axi_wdata[7:0];
            r_nxt.w_strb = s_axi_wstrb[0];
        end
        r_nxt.awready = !r_nxt.aw_held && !r.bvalid;
        r_nxt.wready = !r_nxt.w_held && !r.bvalid;

        // Register write once address and data are both held
        if (r.aw_held && r.w_held && !r.bvalid) begin
            wr_fire = 1'b1;
            r_nxt.aw_held = 1'b0;
            r_nxt.w_held = 1'b0;
            r_nxt.awready = 1'b0;
            r_nxt.wready = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp = `RESP_OKAY;
            case (r.aw_addr)
                `CTRL0_OFS: begin
                    if (r.w_strb) begin
                        r_nxt.ctrl0 = r.w_data & `CTRL0_WR_MASK;
                    end
                end
                `CTRL1_OFS: begin
                    if (r.w_strb) begin
                        r_nxt.ctrl1 = r.w_data & `CTRL1_WR_MASK;
                    end
                end
                `MASK_OFS: begin
                    if (r.w_strb) begin
                        r_nxt.mask = r.w_data[`FLAG_BIT];
                    end
                end
                `ANALOG_SEL_OFS: begin
                    if (r.w_strb) begin
                        r_nxt.analog_sel = r.w_data;
                    end
                end
                `DIR_OFS: begin
                    if (r.w_strb) begin
                        r_nxt.dir = r.w_data;
                    end
                end
                `STATUS_OFS, `PORT_OFS: begin
                    r_nxt.bresp = `RESP_OKAY;
                end
                default: r_nxt.bresp = `RESP_SLVERR;
            endcase
        end
        if (r.bvalid && s_axi_bready) begin
            r_nxt.bvalid = 1'b0;
            r_nxt.awready = !r.aw_held;
            r_nxt.wready = !r.w_held;
        end

        // Read channel
        if (s_axi_arvalid && r.arready) begin
            rd_fire = 1'b1;
            r_nxt.arready = 1'b0;
            r_nxt.rvalid = 1'b1;
            case (s_axi_araddr)
                `CTRL0_OFS: begin
                    rd_byte = r.ctrl0 & `CTRL0_WR_MASK;
                    rd_byte[`CTRL0_RESULT_BIT] = r.result;
                end
                `CTRL1_OFS: rd_byte = r.ctrl1;
                `STATUS_OFS: begin
                    rd_byte[`FLAG_BIT] = r.flag;
                    rd_status = 1'b1;
                end
                `MASK_OFS: rd_byte[`FLAG_BIT] = r.mask;
                `ANALOG_SEL_OFS: rd_byte = r.analog_sel;
                `DIR_OFS: rd_byte = r.dir;
                `PORT_OFS: rd_byte = port_pins_i & ~r.analog_sel;
                default: rd_ok = 1'b0;
            endcase
            r_nxt.rdata = {24'h000000, rd_byte};
            r_nxt.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            r_nxt.rd_port = (s_axi_araddr == `PORT_OFS);
            r_nxt.rd_ctrl0 = (s_axi_araddr == `CTRL0_OFS);
        end
        if (r.rvalid && s_axi_rready) begin
            r_nxt.rvalid = 1'b0;
            r_nxt.arready = 1'b1;
        end

        // Sticky flag, read clears, set wins
        if (rd_status) begin
            r_nxt.flag = 1'b0;
        end
        if (edge_event) begin
            r_nxt.flag = 1'b1;
        end
        r_nxt.irq = r_nxt.flag && r_nxt.mask;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
            r.ctrl0 <= `CTRL0_RESET;
            r.ctrl1 <= `CTRL1_RESET;
            r.dir <= `DIR_RESET;
            r.arready <= 1'b1;
        end else begin
            r <= r_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bresp = r.bresp;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_arready = r.arready;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rvalid = r.rvalid;
    assign pos_route_o = r.pos_route;
    assign neg_route_o = r.neg_route;
    assign speed_power_select_o = r.ctrl0[`CTRL0_SPEED_BIT];
    assign hysteresis_enable_o = r.ctrl0[`CTRL0_HYST_BIT];
    assign timer_sync_enable_o = r.ctrl0[`CTRL0_SYNC_BIT];
    assign comparator_result_o = r.result;
    assign result_pin_oe_o = r.pin_oe;
    // Live levels give closed-loop feedback for auto-restart
    assign pwm_shutdown_src_o = {r.other, r.result};
    assign analog_pin_select_o = r.analog_sel;
    assign pin_direction_o = r.dir;
    assign irq_o = r.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    inputs_gated_a: assert property (
        !r.ctrl0[`CTRL0_EN_BIT] |=> (pos_route_o == 4'h0) && (neg_route_o == 4'h0))
        else $error("Inputs connected while disabled");

    pos_route_a: assert property (
        r.ctrl0[`CTRL0_EN_BIT] && (r.ctrl1[5:4] == 2'b11) |=> pos_route_o == 4'h8)
        else $error("Ground not routed to positive input");

    result_invert_a: assert property (
        r.ctrl0[`CTRL0_EN_BIT] |=> comparator_result_o == ($past(cmp_raw_i) ^ $past(r.ctrl0[4])))
        else $error("Result polarity wrong");

    flag_set_a: assert property (
        edge_event |=> r.flag)
        else $error("Edge did not set flag");

    pol_write_irq_a: assert property (
        $rose(r.ctrl0[`CTRL0_INVERT_BIT]) && !r.ctrl0[`CTRL0_EN_BIT] && !$past(r.ctrl0[`CTRL0_EN_BIT])
        && r.ctrl1[`CTRL1_RISE_BIT] && $stable(r.ctrl1[`CTRL1_RISE_BIT]) |-> ##2 r.flag)
        else $error("Polarity write raised no flag");

    enable_irq_a: assert property (
        $rose(r.ctrl0[`CTRL0_EN_BIT]) && !r.ctrl0[4] && !$past(r.ctrl0[4]) && cmp_raw_i
        && r.ctrl1[`CTRL1_RISE_BIT] && $stable(r.ctrl1[`CTRL1_RISE_BIT]) |-> ##2 r.flag)
        else $error("Enable change raised no flag");

    port_mask_a: assert property (
        s_axi_rvalid && r.rd_port |-> (s_axi_rdata[7:0] & $past(r.analog_sel)) == 8'h00)
        else $error("Analog pin read non-zero");

    ctrl0_layout_a: assert property (
        s_axi_rvalid && r.rd_ctrl0 |-> !s_axi_rdata[3] && (s_axi_rdata[31:8] == 24'h000000))
        else $error("Reserved bits read non-zero");

    reset_value_a: assert property (
        $fell(sys_rst_i) |-> r.ctrl0 == `CTRL0_RESET)
        else $error("Control zero reset value wrong");

    pwm_feed_a: assert property (
        pwm_shutdown_src_o[1] == $past(other_result_i) && pwm_shutdown_src_o[0] == comparator_result_o)
        else $error("PWM shutdown sources wrong");

    irq_level_a: assert property (
        irq_o == (r.flag && r.mask))
        else $error("Interrupt level mismatch");

    neg_route_a: assert property (
        r.ctrl0[`CTRL0_EN_BIT] |=> $onehot(neg_route_o) && neg_route_o[$past(r.ctrl1[`CTRL1_NEG_LSB +: 2])])
        else $error("Negative switch does not follow select");

    pos_onehot_a: assert property (
        r.ctrl0[`CTRL0_EN_BIT] |=> $onehot(pos_route_o) && pos_route_o[$past(r.ctrl1[`CTRL1_POS_LSB +: 2])])
        else $error("Positive switch does not follow select");

    disabled_result_a: assert property (
        !r.ctrl0[`CTRL0_EN_BIT] |=> comparator_result_o == $past(r.ctrl0[`CTRL0_INVERT_BIT]))
        else $error("Disabled result not set by polarity");

    unused_bits_a: assert property (
        !r.ctrl0[`CTRL0_RESULT_BIT] && !r.ctrl0[3])
        else $error("Stored read-only bits not zero");

    flag_sticky_a: assert property (
        r.flag && !rd_status |=> r.flag)
        else $error("Flag dropped without status read");

    flag_clear_a: assert property (
        rd_status && !edge_event |=> !r.flag)
        else $error("Status read did not clear flag");

    write_answer_a: assert property (
        wr_fire |=> s_axi_bvalid)
        else $error("Write response missing");

    read_answer_a: assert property (
        rd_fire |=> s_axi_rvalid)
        else $error("Read data missing");

    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped early");

endmodule

// ==== rtl/comparator_input_control_pkg.sv ====
// Purpose: Types shared by the comparator control block
// Assumes: Nothing
// Notes: Constants live in the _regs header
package comparator_input_control_pkg;

    typedef enum logic [1:0] {
        POS_EXT_PIN = 2'b00,
        POS_DAC = 2'b01,
        POS_FIXED_REF = 2'b10,
        POS_GROUND = 2'b11
    } pos_src_type;

    typedef struct packed {
        logic prev;
    } edge_state_type;

    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic flag;
        logic mask;
        logic [7:0] analog_sel;
        logic [7:0] dir;
        logic result;
        logic other;
        logic [3:0] pos_route;
        logic [3:0] neg_route;
        logic pin_oe;
        logic irq;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic rd_port;
        logic rd_ctrl0;
    } ctrl_state_type;

endpackage

// ==== rtl/comparator_input_control_regs.svh ====
// Purpose: Register offsets, field positions, reset values for the comparator control block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: Definitions only
`ifndef COMPARATOR_INPUT_CONTROL_REGS_SVH
`define COMPARATOR_INPUT_CONTROL_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define CTRL0_OFS 8'h00
`define CTRL1_OFS 8'h04
`define STATUS_OFS 8'h08
`define MASK_OFS 8'h0c
`define ANALOG_SEL_OFS 8'h10
`define DIR_OFS 8'h14
`define PORT_OFS 8'h18

// ----------------------------------------
// Control zero fields
// ----------------------------------------
`define CTRL0_EN_BIT 7
`define CTRL0_RESULT_BIT 6
`define CTRL0_PIN_EN_BIT 5
`define CTRL0_INVERT_BIT 4
`define CTRL0_SPEED_BIT 2
`define CTRL0_HYST_BIT 1
`define CTRL0_SYNC_BIT 0
`define CTRL0_WR_MASK 8'hb7
`define CTRL0_RESET 8'h04

// ----------------------------------------
// Control one fields
// ----------------------------------------
`define CTRL1_RISE_BIT 7
`define CTRL1_FALL_BIT 6
`define CTRL1_POS_LSB 4
`define CTRL1_NEG_LSB 0
`define CTRL1_WR_MASK 8'hf3
`define CTRL1_RESET 8'h00

// ----------------------------------------
// Other resets and bus answers
// ----------------------------------------
`define FLAG_BIT 0
`define DIR_RESET 8'hff
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== rtl/edge_irq_detect.sv ====
// Purpose: Rising and falling edge detection on the latched comparator result
// Assumes: Result is already registered in the core clock domain
// Notes: Event output is combinational, one cycle per edge
`timescale 1ns/1ps
module edge_irq_detect
    import comparator_input_control_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic result_i,
    input wire logic rise_en_i,
    input wire logic fall_en_i,
    output logic event_o
);

    edge_state_type r;
    edge_state_type r_nxt;

    always_comb begin
        r_nxt = r;
        r_nxt.prev = result_i;
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    // Either enabled edge raises the event
    assign event_o = (rise_en_i && result_i && !r.prev) || (fall_en_i && !result_i && r.prev);

endmodule

// ==== test/analog_source_model.sv ====
// Purpose: Behavioural analog sources and pins behind the comparator switches
// Assumes: Levels are plain codes, ground source is level zero
// Notes: Output toggles while unrouted or settling, so nothing stale is seen
`timescale 1ns/1ps
module analog_source_model #(
    parameter int SETTLE = 3
)
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] pos_route_i,
    input wire logic [3:0] neg_route_i,
    input wire logic [3:0][7:0] pos_lvl_i,
    input wire logic [3:0][7:0] neg_lvl_i,
    output logic cmp_raw_o
);
    logic [3:0] pos_q;
    logic [3:0] neg_q;
    logic [7:0] vp;
    logic [7:0] vn;
    int settle_cnt;

    always_comb begin
        vp = 8'h00;
        vn = 8'h00;
        for (int k = 0; k < 4; k++) begin
            if (pos_route_i[k] && k != 3) begin
                vp = pos_lvl_i[k];
            end
            if (neg_route_i[k]) begin
                vn = neg_lvl_i[k];
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_raw_o <= 1'b0;
            settle_cnt <= 0;
            pos_q <= 4'h0;
            neg_q <= 4'h0;
        end else begin
            pos_q <= pos_route_i;
            neg_q <= neg_route_i;
            if (pos_q != pos_route_i || neg_q != neg_route_i) begin
                settle_cnt <= SETTLE;
            end else if (settle_cnt > 0) begin
                settle_cnt <= settle_cnt - 1;
            end
            // Unrouted or settling: indeterminate, so keep changing
            if (!$onehot(pos_route_i) || !$onehot(neg_route_i) || settle_cnt != 0) begin
                cmp_raw_o <= ~cmp_raw_o;
            end else begin
                cmp_raw_o <= (vp > vn);
            end
        end
    end
endmodule

// ==== test/test_comparator_input_control.sv ====
// Purpose: Self-checking bench for the comparator control block
// Assumes: AXI4-Lite master tasks, 50 MHz clock, fixed seed
// Notes: Expectations come from bench functions and constants only
`timescale 1ns/1ps
`include "comparator_input_control_regs.svh"
module test_comparator_input_control;
    import comparator_input_control_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, port_pins = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, cmp_raw, other_result = 1'b0;
    logic [1:0] bresp, rresp, pwm_src;
    logic [31:0] rdata;
    logic [3:0] pos_route, neg_route;
    logic speed_sel, hyst_en, sync_en, result, pin_oe, irq;
    logic [7:0] analog_sel, pdir, sel;
    logic [3:0][7:0] pos_lvl = '0, neg_lvl = '0;
    int n_errors = 0, total_checks = 0, cycles = 0, seed = 32'h9de0;
    logic [31:0] rd;
    logic [1:0] resp;
    logic inv;

    always #10 core_clk_i = ~core_clk_i;

    comparator_input_control comparator_input_control_inst (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cmp_raw_i(cmp_raw), .other_result_i(other_result), .port_pins_i(port_pins),
        .pos_route_o(pos_route), .neg_route_o(neg_route), .speed_power_select_o(speed_sel),
        .hysteresis_enable_o(hyst_en), .timer_sync_enable_o(sync_en), .comparator_result_o(result),
        .result_pin_oe_o(pin_oe), .pwm_shutdown_src_o(pwm_src), .analog_pin_select_o(analog_sel),
        .pin_direction_o(pdir), .irq_o(irq));

    analog_source_model analog_source_model_inst (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .pos_route_i(pos_route),
        .neg_route_i(neg_route), .pos_lvl_i(pos_lvl), .neg_lvl_i(neg_lvl), .cmp_raw_o(cmp_raw));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Bus master
    // ----------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        r = 2'bxx;
        for (int t = 0; t < 200; t++) begin
            @(posedge core_clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        d = 32'hx;
        r = 2'bxx;
        for (int t = 0; t < 200; t++) begin
            @(posedge core_clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        axi_write(a, {24'h0, d}, resp);
        check({30'h0, resp}, {30'h0, `RESP_OKAY}, "write response");
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    function automatic logic exp_result(input int p, input int n, input logic pol);
        logic [7:0] vp;
        vp = (p == 3) ? 8'h00 : pos_lvl[p];
        return (vp > neg_lvl[n]) ^ pol;
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        axi_read(`CTRL0_OFS, rd, resp);
        check(rd, {24'h0, `CTRL0_RESET}, "control zero reset");
        check({31'h0, speed_sel}, 32'h1, "speed select at reset");
        check({24'h0, pdir}, {24'h0, `DIR_RESET}, "direction reset");
        axi_read(8'h40, rd, resp);
        check({30'h0, resp}, {30'h0, `RESP_SLVERR}, "unmapped read");
        wr(`CTRL0_OFS, 8'h7f);
        wait_cyc(3);
        axi_read(`CTRL0_OFS, rd, resp);
        check(rd, 32'h77, "read only and unused bits");
        check({29'h0, speed_sel, hyst_en, sync_en}, 32'h7, "control zero fields");
        $display("test register layout done");

        // Every select pair, random levels and polarity
        wr(`ANALOG_SEL_OFS, 8'hff);
        wr(`DIR_OFS, 8'hff);
        for (int i = 0; i < 16; i++) begin
            pos_lvl <= {$random(seed)} & 32'h7f7f7f7f;
            neg_lvl <= {$random(seed)} & 32'h7f7f7f7f;
            other_result <= 1'($random(seed));
            inv = 1'($random(seed));
            wait_cyc(1);
            if (pos_lvl[i / 4] == neg_lvl[i % 4]) neg_lvl[i % 4] <= pos_lvl[i / 4] + 8'h01;
            wr(`CTRL1_OFS, 8'(((i / 4) << 4) | (i % 4)));
            wr(`CTRL0_OFS, {3'b100, inv, 4'h4});
            wait_cyc(10);
            check({28'h0, pos_route}, 32'h1 << (i / 4), "positive switch");
            check({28'h0, neg_route}, 32'h1 << (i % 4), "negative switch");
            check({31'h0, result}, {31'h0, exp_result(i / 4, i % 4, inv)}, "result");
            check({30'h0, pwm_src}, {30'h0, other_result, exp_result(i / 4, i % 4, inv)}, "shutdown src");
            axi_read(`CTRL0_OFS, rd, resp);
            check({31'h0, rd[6]}, {31'h0, exp_result(i / 4, i % 4, inv)}, "result bit");
        end
        wr(`CTRL0_OFS, 8'h04);
        wait_cyc(3);
        check({24'h0, pos_route, neg_route}, 32'h0, "inputs off when disabled");
        $display("test input selection done");

        // Interrupts from polarity and enable writes
        wr(`CTRL1_OFS, 8'hc0);
        wr(`MASK_OFS, 8'h01);
        axi_read(`STATUS_OFS, rd, resp);
        wait_cyc(3);
        wr(`CTRL0_OFS, 8'h14);
        wait_cyc(4);
        check({31'h0, irq}, 32'h1, "irq from polarity write");
        axi_read(`STATUS_OFS, rd, resp);
        check(rd, 32'h1, "status flag");
        wait_cyc(3);
        check({31'h0, irq}, 32'h0, "irq cleared by read");
        pos_lvl[0] <= 8'h70;
        neg_lvl[0] <= 8'h10;
        wr(`CTRL0_OFS, 8'h94);
        wait_cyc(10);
        check({31'h0, irq}, 32'h1, "irq from enable write");
        wr(`MASK_OFS, 8'h00);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0, "masked irq");
        axi_read(`STATUS_OFS, rd, resp);
        wr(`CTRL0_OFS, 8'h14);
        wait_cyc(4);
        axi_read(`STATUS_OFS, rd, resp);
        check(rd, 32'h1, "flag from disable write");
        wr(`CTRL1_OFS, 8'h00);
        wr(`CTRL0_OFS, 8'h04);
        wait_cyc(10);
        axi_read(`STATUS_OFS, rd, resp);
        wr(`CTRL0_OFS, 8'h14);
        wait_cyc(4);
        axi_read(`STATUS_OFS, rd, resp);
        check(rd, 32'h0, "no flag with edges off");
        $display("test interrupts done");

        // Port reads hide analog pins
        for (int i = 0; i < 8; i++) begin
            port_pins <= 8'($random(seed));
            sel = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            wr(`ANALOG_SEL_OFS, sel);
            axi_read(`PORT_OFS, rd, resp);
            check(rd, {24'h0, port_pins & ~sel}, "port read");
            check({24'h0, analog_sel}, {24'h0, sel}, "analog select out");
        end
        $display("test port read done");

        // Result pin drive and a second reset
        wr(`DIR_OFS, 8'hfe);
        wr(`CTRL0_OFS, 8'h24);
        wait_cyc(3);
        check({31'h0, pin_oe}, 32'h1, "result pin driven");
        check({24'h0, pdir}, 32'hfe, "direction out");
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        axi_read(`CTRL0_OFS, rd, resp);
        check(rd, {24'h0, `CTRL0_RESET}, "control zero after reset");
        check({31'h0, pin_oe}, 32'h0, "pin drive off after reset");
        $display("test reset done");
        end_sim();
    end
endmodule
